// ===== rtl/asou_pkg.sv
// Constants for the address and scalar operations unit
package asou_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int AW = 24;
	localparam int SW = 64;

	// ----------------------------------------
	// Opcodes (gh field)
	// ----------------------------------------
	localparam logic [6:0] OP_ABR_ZERO = 7'h08;
	localparam logic [6:0] OP_ABR_NZ   = 7'h09;
	localparam logic [6:0] OP_ABR_POS  = 7'h0A;
	localparam logic [6:0] OP_ABR_NEG  = 7'h0B;
	localparam logic [6:0] OP_SBR_ZERO = 7'h0C;
	localparam logic [6:0] OP_SBR_NZ   = 7'h0D;
	localparam logic [6:0] OP_SBR_POS  = 7'h0E;
	localparam logic [6:0] OP_SBR_NEG  = 7'h0F;
	localparam logic [6:0] OP_IMM     = 7'h10;
	localparam logic [6:0] OP_IMM_INV = 7'h11;
	localparam logic [6:0] OP_IMM6    = 7'h12;
	localparam logic [6:0] OP_S_TO_A  = 7'h13;
	localparam logic [6:0] OP_B_TO_A  = 7'h14;
	localparam logic [6:0] OP_A_TO_B  = 7'h15;
	localparam logic [6:0] OP_POP     = 7'h16;
	localparam logic [6:0] OP_LZC     = 7'h17;
	localparam logic [6:0] OP_ADD     = 7'h18;
	localparam logic [6:0] OP_SUB     = 7'h19;
	localparam logic [6:0] OP_MUL     = 7'h1A;

	// ----------------------------------------
	// Issue times in clock periods
	// ----------------------------------------
	localparam logic [4:0] CP_ONE       = 5'h01;
	localparam logic [4:0] CP_NT_SAME   = 5'h02;
	localparam logic [4:0] CP_NT_SPLIT  = 5'h04;
	localparam logic [4:0] CP_NT_MISS   = 5'h0D;
	localparam logic [4:0] CP_TK_SAME   = 5'h05;
	localparam logic [4:0] CP_TK_SAME_M = 5'h0E;
	localparam logic [4:0] CP_TK_SPLIT  = 5'h07;
	localparam logic [4:0] CP_TK_SPL_M  = 5'h10;
	localparam logic [4:0] CP_TK_MISS   = 5'h10;
	localparam logic [4:0] CP_TK_MISS_M = 5'h19;

	// ----------------------------------------
	// Result ready times in clock periods
	// ----------------------------------------
	localparam logic [4:0] RDY_MOVE = 5'h01;
	localparam logic [4:0] RDY_ADD  = 5'h02;
	localparam logic [4:0] RDY_LZC  = 5'h03;
	localparam logic [4:0] RDY_POP  = 5'h04;
	localparam logic [4:0] RDY_MUL  = 5'h06;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [23:0] PC_RST = 24'h000000;
	localparam logic [6:0]  LZC_ALL = 7'h40;

endpackage : asou_pkg

// ===== rtl/asou_unit.sv
// Branch, address transmit and address arithmetic unit
// How it works
// - taken scalar branch loads low 24 target bits
// - untaken branch continues after both parcels
// - zero register value counts as positive
// - taken branch takes 5/14/7/16/16/25 periods
// - untaken branch takes 2/4/13 periods
// - scalar branch held while scalar zero recently busy
// - block transfer or exchange holds every issue
// - immediate transmit zero extends 22 bits
// - complement immediate inverts extended field
// - immediates issue 2/4/13, ready one later
// - short immediate fills low six bits
// - scalar to address takes low 24 bits
// - B/A copies; only B-to-A checks conflict
// - population count into low seven bits
// - parity writes count bit zero only
// - count issues one period, ready after four
// - leading zeros, ready three, 64 for j0
// - add with j0 as 0, k0 as 1
// - subtract with the same substitutions
// - add and subtract ready after two
// - multiply keeps low 24 product bits
// - hold on conflict or reserved registers
`timescale 1ns/1ps
`default_nettype none

module asou_unit
	import asou_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                 CLK,
	input  wire logic                 RSTN,
	input  wire logic                 CE,
	// Decoded instruction from issue control
	input  wire logic                 IN_VALID,
	input  wire logic [6:0]           IN_OP,
	input  wire logic [2:0]           IN_I,
	input  wire logic [2:0]           IN_J,
	input  wire logic [2:0]           IN_K,
	input  wire logic [15:0]          IN_M,
	// Instruction buffer status
	input  wire logic                 IN_SPLIT,
	input  wire logic                 IN_P2_MISS,
	input  wire logic                 IN_TGT_MISS,
	// Hold sources
	input  wire logic                 IN_BLK_XFER,
	input  wire logic                 IN_EXCHANGE,
	input  wire logic                 IN_A_CONFLICT,
	input  wire logic                 IN_SJ_RESERVED,
	input  wire logic                 IN_SRZ_BUSY,
	// Operand data
	input  wire logic [asou_pkg::SW-1:0] IN_SRZ_DATA,
	input  wire logic [asou_pkg::SW-1:0] IN_SJ_DATA,
	input  wire logic [asou_pkg::AW-1:0] IN_B_DATA,
	// Program counter load (exchange)
	input  wire logic                 IN_PC_LOAD,
	input  wire logic [asou_pkg::AW-1:0] IN_PC_VALUE,
	// Results and status
	output logic [asou_pkg::AW-1:0]   OUT_PC,
	output logic [8*asou_pkg::AW-1:0] OUT_A_FILE,
	output logic [7:0]                OUT_A_RESERVED,
	output logic                      OUT_ISSUED,
	output logic                      OUT_BUSY,
	output logic                      OUT_B_WE,
	output logic [5:0]                OUT_B_IDX,
	output logic [asou_pkg::AW-1:0]   OUT_B_DATA
);
	import asou_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [23:0]      pc;
		logic [7:0][23:0] a;
		logic [7:0][4:0]  rcnt;
		logic [7:0][23:0] rdat;
		logic [7:0]       res;
		logic [4:0]       bcnt;
		logic             busy;
		logic [1:0]       s0h;
		logic             issued;
		logic             bwe;
		logic [5:0]       bidx;
		logic [23:0]      bdat;
	} asou_state_s;

	asou_state_s s_r;
	asou_state_s s_nxt;

	// ----------------------------------------
	// Counting functions
	// ----------------------------------------
	function automatic logic [6:0] f_pop(input logic [63:0] v);
		logic [6:0] c;
		c = 7'h00;
		for (int b = 0; b < 64; b++) begin
			c = c + {6'h00, v[b]};
		end
		return c;
	endfunction : f_pop

	// Scan from the top; first one found sets the count
	function automatic logic [6:0] f_lzc(input logic [63:0] v);
		logic [6:0] c;
		logic       seen;
		c = LZC_ALL;
		seen = 1'b0;
		for (int b = 63; b >= 0; b--) begin
			if (v[b] && !seen) begin
				c = 7'(63 - b);
				seen = 1'b1;
			end
		end
		return c;
	endfunction : f_lzc

	// ----------------------------------------
	// Operand selection
	// ----------------------------------------
	logic [21:0] jkm;
	logic [23:0] tgt;
	logic [63:0] sj_val;
	logic [23:0] opa;
	logic [23:0] opb;
	logic [47:0] prod;
	logic        is_abr;
	logic        is_sbr;
	logic        srz_recent;
	logic [6:0]  pop_cnt;

	assign jkm       = {IN_J, IN_K, IN_M};
	assign pop_cnt   = f_pop(sj_val);
	assign tgt       = {IN_I[1:0], IN_J, IN_K, IN_M};
	assign sj_val    = (IN_J == 3'h0) ? 64'h0 : IN_SJ_DATA;
	assign opa       = (IN_J == 3'h0) ? 24'h000000 : s_r.a[IN_J];
	assign opb       = (IN_K == 3'h0) ? 24'h000001 : s_r.a[IN_K];
	assign prod      = s_r.a[IN_J] * s_r.a[IN_K];
	assign is_abr    = IN_OP[6:2] == OP_ABR_ZERO[6:2];
	assign is_sbr    = IN_OP[6:2] == OP_SBR_ZERO[6:2];
	assign srz_recent = IN_SRZ_BUSY | (|s_r.s0h);

	// ----------------------------------------
	// Decode: result, timing, holds
	// ----------------------------------------
	logic        known;
	logic        hold_op;
	logic        wr_a;
	logic        taken;
	logic        t_zero;
	logic        t_neg;
	logic [23:0] result;
	logic [4:0]  lat;
	logic [4:0]  nt_cp;
	logic [4:0]  tk_cp;
	logic [4:0]  issue_cp;
	logic        accept;

	always_comb begin
		known   = 1'b1;
		hold_op = IN_A_CONFLICT | s_r.res[IN_I];
		wr_a    = 1'b1;
		result  = 24'h000000;
		lat     = RDY_MOVE;
		// Zero counts as positive for both tested registers
		t_zero  = is_sbr ? (IN_SRZ_DATA == 64'h0) : (s_r.a[0] == 24'h000000);
		t_neg   = is_sbr ? IN_SRZ_DATA[63] : s_r.a[0][23];
		case (IN_OP[1:0])
			2'h0: taken = t_zero;
			2'h1: taken = !t_zero;
			2'h2: taken = !t_neg;
			default: taken = t_neg;
		endcase
		// Buffer status picks the issue time
		nt_cp = IN_P2_MISS ? CP_NT_MISS : (IN_SPLIT ? CP_NT_SPLIT : CP_NT_SAME);
		if (IN_P2_MISS) begin
			tk_cp = IN_TGT_MISS ? CP_TK_MISS_M : CP_TK_MISS;
		end else if (IN_SPLIT) begin
			tk_cp = IN_TGT_MISS ? CP_TK_SPL_M : CP_TK_SPLIT;
		end else begin
			tk_cp = IN_TGT_MISS ? CP_TK_SAME_M : CP_TK_SAME;
		end
		issue_cp = CP_ONE;
		if (is_abr || is_sbr) begin
			wr_a     = 1'b0;
			issue_cp = taken ? tk_cp : nt_cp;
			// Address-register tests wait for a pending address zero write
			hold_op  = is_sbr ? srz_recent : s_r.res[0];
		end else begin
			unique case (IN_OP)
				OP_IMM: begin
					result   = {2'b00, jkm};
					issue_cp = nt_cp;
					lat      = nt_cp + RDY_MOVE;
				end
				OP_IMM_INV: begin
					result   = ~{2'b00, jkm};
					issue_cp = nt_cp;
					lat      = nt_cp + RDY_MOVE;
				end
				OP_IMM6: result = {18'h00000, IN_J, IN_K};
				OP_S_TO_A: begin
					result  = sj_val[23:0];
					hold_op = hold_op | IN_SJ_RESERVED;
				end
				OP_B_TO_A: result = IN_B_DATA;
				OP_A_TO_B: begin
					wr_a    = 1'b0;
					hold_op = s_r.res[IN_I];
				end
				OP_POP: begin
					// k of zero selects the count, otherwise its parity
					result  = (IN_K == 3'h0) ? {17'h00000, pop_cnt}
							: {23'h000000, pop_cnt[0]};
					lat     = RDY_POP;
					hold_op = hold_op | IN_SJ_RESERVED;
				end
				OP_LZC: begin
					result  = {17'h00000, f_lzc(sj_val)};
					lat     = RDY_LZC;
					hold_op = hold_op | IN_SJ_RESERVED;
				end
				OP_ADD: begin
					result  = opa + opb;
					lat     = RDY_ADD;
					hold_op = hold_op | s_r.res[IN_J] | s_r.res[IN_K];
				end
				OP_SUB: begin
					result  = opa - opb;
					lat     = RDY_ADD;
					hold_op = hold_op | s_r.res[IN_J] | s_r.res[IN_K];
				end
				OP_MUL: begin
					result  = prod[23:0];
					lat     = RDY_MUL;
					hold_op = hold_op | s_r.res[IN_J] | s_r.res[IN_K];
				end
				default: begin
					known = 1'b0;
					wr_a  = 1'b0;
				end
			endcase
		end
	end

	// Block transfer and exchange freeze all issue
	assign accept = IN_VALID & known & ~hold_op & ~s_r.busy
			& ~IN_BLK_XFER & ~IN_EXCHANGE;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt        = s_r;
		s_nxt.issued = 1'b0;
		s_nxt.bwe    = 1'b0;
		s_nxt.s0h    = {s_r.s0h[0], IN_SRZ_BUSY};
		// Pending results land and release their reservation
		for (int r = 0; r < 8; r++) begin
			if (s_r.rcnt[r] != 5'h00) begin
				s_nxt.rcnt[r] = s_r.rcnt[r] - 5'h01;
				if (s_r.rcnt[r] == 5'h01) begin
					s_nxt.a[r]   = s_r.rdat[r];
					s_nxt.res[r] = 1'b0;
				end
			end
		end
		if (s_r.bcnt != 5'h00) begin
			s_nxt.bcnt = s_r.bcnt - 5'h01;
		end
		if (accept) begin
			s_nxt.issued = 1'b1;
			s_nxt.bcnt   = issue_cp - 5'h01;
			if (is_abr || is_sbr) begin
				s_nxt.pc = taken ? tgt : s_r.pc + 24'h000002;
			end else begin
				s_nxt.pc = s_r.pc + ((IN_OP == OP_IMM || IN_OP == OP_IMM_INV)
						? 24'h000002 : 24'h000001);
			end
			// Single-period results skip the reservation entirely
			if (wr_a && lat == RDY_MOVE) begin
				s_nxt.a[IN_I] = result;
			end else if (wr_a) begin
				s_nxt.rcnt[IN_I] = lat - 5'h01;
				s_nxt.rdat[IN_I] = result;
				s_nxt.res[IN_I]  = 1'b1;
			end
			if (IN_OP == OP_A_TO_B) begin
				s_nxt.bwe  = 1'b1;
				s_nxt.bidx = {IN_J, IN_K};
				s_nxt.bdat = s_r.a[IN_I];
			end
		end
		if (IN_PC_LOAD) begin
			s_nxt.pc = IN_PC_VALUE;
		end
		s_nxt.busy = s_nxt.bcnt != 5'h00;
	end

	// State register; CE low freezes everything
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			s_r    <= '0;
			s_r.pc <= PC_RST;
		end else if (CE) begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign OUT_PC         = s_r.pc;
	assign OUT_A_FILE     = s_r.a;
	assign OUT_A_RESERVED = s_r.res;
	assign OUT_ISSUED     = s_r.issued;
	assign OUT_BUSY       = s_r.busy;
	assign OUT_B_WE       = s_r.bwe;
	assign OUT_B_IDX      = s_r.bidx;
	assign OUT_B_DATA     = s_r.bdat;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_tk_pc;
		@(posedge CLK) disable iff (!RSTN || !CE)
		accept && is_sbr && taken && !IN_PC_LOAD |=> s_r.pc == $past(tgt);
	endproperty
	a_tk_pc: assert property (p_tk_pc) else $error("taken branch pc wrong");

	property p_nt_pc;
		@(posedge CLK) disable iff (!RSTN || !CE)
		accept && (is_abr || is_sbr) && !taken && !IN_PC_LOAD
		|=> s_r.pc == $past(s_r.pc) + 24'h000002;
	endproperty
	a_nt_pc: assert property (p_nt_pc) else $error("untaken branch pc wrong");

	property p_zero_pos;
		@(posedge CLK) disable iff (!RSTN || !CE)
		IN_OP == OP_SBR_POS && IN_SRZ_DATA == 64'h0 |-> taken;
	endproperty
	a_zero_pos: assert property (p_zero_pos) else $error("zero not positive");

	property p_tk_time;
		@(posedge CLK) disable iff (!RSTN || !CE)
		accept && is_sbr && taken && !IN_SPLIT && !IN_P2_MISS && !IN_TGT_MISS
		|=> OUT_BUSY[*4] ##1 !OUT_BUSY;
	endproperty
	a_tk_time: assert property (p_tk_time) else $error("taken branch time wrong");

	property p_nt_time;
		@(posedge CLK) disable iff (!RSTN || !CE)
		accept && is_sbr && !taken && IN_SPLIT && !IN_P2_MISS
		|=> OUT_BUSY[*3] ##1 !OUT_BUSY;
	endproperty
	a_nt_time: assert property (p_nt_time) else $error("untaken time wrong");

	property p_srz_hold;
		@(posedge CLK) disable iff (!RSTN || !CE)
		is_sbr && ($past(IN_SRZ_BUSY) || $past(IN_SRZ_BUSY, 2)) |-> !accept;
	endproperty
	a_srz_hold: assert property (p_srz_hold) else $error("scalar zero busy not held");

	property p_blk_hold;
		@(posedge CLK) disable iff (!RSTN || !CE)
		IN_BLK_XFER || IN_EXCHANGE |=> !OUT_ISSUED;
	endproperty
	a_blk_hold: assert property (p_blk_hold) else $error("issued during block");

	property p_imm_val;
		@(posedge CLK) disable iff (!RSTN || !CE)
		accept && IN_OP == OP_IMM && !IN_SPLIT && !IN_P2_MISS
		|-> ##3 s_r.a[$past(IN_I, 3)] == {2'b00, $past(jkm, 3)};
	endproperty
	a_imm_val: assert property (p_imm_val) else $error("immediate value wrong");

	property p_pop_zero;
		@(posedge CLK) disable iff (!RSTN || !CE)
		accept && IN_OP == OP_POP && IN_J == 3'h0
		|-> ##4 s_r.a[$past(IN_I, 4)] == 24'h000000;
	endproperty
	a_pop_zero: assert property (p_pop_zero) else $error("pop count of j0 nonzero");

	property p_add_val;
		@(posedge CLK) disable iff (!RSTN || !CE)
		accept && IN_OP == OP_ADD
		|-> ##2 s_r.a[$past(IN_I, 2)] == $past(opa, 2) + $past(opb, 2);
	endproperty
	a_add_val: assert property (p_add_val) else $error("address sum wrong");

	property p_resv_hold;
		@(posedge CLK) disable iff (!RSTN || !CE)
		IN_OP == OP_ADD && s_r.res[IN_J] |-> !accept;
	endproperty
	a_resv_hold: assert property (p_resv_hold) else $error("reserved source issued");

	property p_resv_set;
		@(posedge CLK) disable iff (!RSTN || !CE)
		accept && IN_OP == OP_MUL |=> OUT_A_RESERVED[$past(IN_I)];
	endproperty
	a_resv_set: assert property (p_resv_set) else $error("destination not reserved");

endmodule : asou_unit

`default_nettype wire

// ===== test/asou_issue_src.sv
// Issue control stand-in that feeds queued instructions to the unit
`timescale 1ns/1ps
`default_nettype none

module asou_issue_src (
	// Clock and answer
	input  wire logic        clk,
	input  wire logic        issued,
	// Instruction request
	output logic             valid,
	output logic [34:0]      fld
);
	logic [34:0] q[$];
	logic [34:0] cur;

	// ----------------------------------------
	// Request held until the unit takes it
	// ----------------------------------------
	initial begin
		valid = 1'b0;
		cur = '0;
		fld = '1;
		forever begin
			@(posedge clk);
			#1;
			if ((!valid || issued) && q.size() > 0) begin
				cur = q.pop_front();
				fld = cur;
				valid = 1'b1;
			end else if (valid && issued) begin
				// Released fields flip so stale bits cannot pass for a request
				fld = ~cur;
				valid = 1'b0;
			end
		end
	end

	// Queue one instruction
	task automatic send(input logic [34:0] w);
		q.push_back(w);
	endtask : send
endmodule : asou_issue_src

`default_nettype wire

// ===== test/address_scalar_ops_unit_bench.sv
// Self-checking bench for the address and scalar operations unit
`timescale 1ns/1ps
`default_nettype none

module address_scalar_ops_unit_bench;
	import asou_pkg::*;
	typedef struct {
		logic [2:0]  ai;
		logic [23:0] pc;
		logic [23:0] av;
		logic [5:0]  bx;
		int          lat;
		int          it;
	} asou_note_s;
	logic            clk;
	logic            rstn;
	logic            valid;
	logic [34:0]     fld;
	logic [4:0]      hold;
	logic [SW-1:0]   srz_d;
	logic [5:0]      bidx;
	logic [SW-1:0]   sj_d;
	logic [AW-1:0]   b_d;
	logic [AW-1:0]   pc_o;
	logic [AW-1:0]   b_o;
	logic [8*AW-1:0] af;
	logic [7:0]      ares;
	logic            iss;
	logic            busy;
	logic            bwe;
	logic [23:0]     a_m [8];
	logic [23:0]     pc_m;
	logic [15:0]     lf;
	int              err_count;
	int              n_checks;
	int              n_iss;
	asou_note_s      notes[$];

	// ----------------------------------------
	// Unit and issue source
	// ----------------------------------------
	asou_unit dut (
		.CLK(clk), .RSTN(rstn), .CE(1'b1), .IN_VALID(valid),
		.IN_OP(fld[34:28]), .IN_I(fld[27:25]), .IN_J(fld[24:22]), .IN_K(fld[21:19]),
		.IN_M(fld[18:3]), .IN_SPLIT(fld[0]), .IN_P2_MISS(fld[1]), .IN_TGT_MISS(fld[2]),
		.IN_BLK_XFER(hold[0]), .IN_EXCHANGE(hold[1]), .IN_A_CONFLICT(hold[2]),
		.IN_SJ_RESERVED(hold[3]), .IN_SRZ_BUSY(hold[4]), .IN_SRZ_DATA(srz_d),
		.IN_SJ_DATA(sj_d), .IN_B_DATA(b_d), .IN_PC_LOAD(1'b0), .IN_PC_VALUE(24'h000000),
		.OUT_PC(pc_o), .OUT_A_FILE(af), .OUT_A_RESERVED(ares), .OUT_ISSUED(iss),
		.OUT_BUSY(busy), .OUT_B_WE(bwe), .OUT_B_IDX(bidx), .OUT_B_DATA(b_o)
	);
	asou_issue_src src (.clk(clk), .issued(iss), .valid(valid), .fld(fld));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr

	function automatic logic [23:0] lzc(input logic [63:0] v);
		lzc = 24'h000040;
		for (int b = 0; b < 64; b++) if (v[b]) lzc = 24'(63 - b);
	endfunction : lzc

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick

	// Work out the expected outcome, note it and queue the instruction
	task automatic do_op(input logic [6:0] o, input logic [2:0] i, j, k,
		input logic [15:0] m, input logic [2:0] bs);
		asou_note_s n;
		logic [23:0] x;
		logic [23:0] y;
		logic        tk;
		logic        z;
		logic        ng;
		x = (j == 3'h0) ? 24'h000000 : a_m[j];
		y = (k == 3'h0) ? 24'h000001 : a_m[k];
		tk = 1'b0;
		n.it = 1;
		n.lat = 0;
		n.av = 24'h000000;
		if (o[6:3] == 4'h1) begin
			z = o[2] ? (srz_d == '0) : (a_m[0] == '0);
			ng = o[2] ? srz_d[63] : a_m[0][23];
			tk = (o[1:0] == 2'h0) ? z : (o[1:0] == 2'h1) ? !z : (o[1:0] == 2'h2) ? !ng : ng;
			n.it = bs[1] ? (tk ? (bs[2] ? 25 : 16) : 13) : bs[0] ? (tk ? (bs[2] ? 16 : 7) : 4)
				: (tk ? (bs[2] ? 14 : 5) : 2);
		end
		if (o == OP_IMM || o == OP_IMM_INV) n.it = bs[1] ? 13 : bs[0] ? 4 : 2;
		case (o)
			OP_IMM:     n.av = {2'b00, j, k, m};
			OP_IMM_INV: n.av = ~{2'b00, j, k, m};
			OP_IMM6:    n.av = {18'h00000, j, k};
			OP_S_TO_A:  n.av = (j == 3'h0) ? 24'h000000 : sj_d[23:0];
			OP_B_TO_A:  n.av = b_d;
			OP_A_TO_B:  n.av = a_m[i];
			OP_POP:     n.av = (j == 3'h0) ? 24'h000000 : (k == 3'h0) ? 24'($countones(sj_d))
				: 24'($countones(sj_d) % 2);
			OP_LZC:     n.av = (j == 3'h0) ? 24'h000040 : lzc(sj_d);
			OP_ADD:     n.av = x + y;
			OP_SUB:     n.av = x - y;
			OP_MUL:     n.av = a_m[j] * a_m[k];
			default:    n.av = 24'h000000;
		endcase
		case (o)
			OP_IMM, OP_IMM_INV:              n.lat = n.it + 1;
			OP_IMM6, OP_S_TO_A, OP_B_TO_A:  n.lat = 1;
			OP_A_TO_B:                       n.lat = -1;
			OP_POP:                          n.lat = 4;
			OP_LZC:                          n.lat = 3;
			OP_ADD, OP_SUB:                  n.lat = 2;
			OP_MUL:                          n.lat = 6;
			default:                         n.lat = 0;
		endcase
		if (n.lat > 0) a_m[i] = n.av;
		pc_m = tk ? {i[1:0], j, k, m} : pc_m + ((o <= OP_IMM_INV) ? 24'h000002 : 24'h000001);
		n.pc = pc_m;
		n.ai = i;
		n.bx = {j, k};
		notes.push_back(n);
		src.send({o, i, j, k, m, bs});
	endtask : do_op

	// Wait until every queued instruction has issued and landed
	task automatic drain();
		int c;
		c = 0;
		while ((notes.size() != 0 || busy !== 1'b0 || ares !== 8'h00) && c < 300) begin
			tick();
			c++;
		end
		if (c >= 300) check("drain finished", 1'b0, 1'b1);
	endtask : drain

	// Hold one source, prove nothing issues, then release it
	task automatic held(input int h, input logic [6:0] o);
		int n0;
		tick();
		hold[h] = 1'b1;
		n0 = n_iss;
		do_op(o, 3'h2, 3'h1, 3'h0, 16'h0000, 3'h0);
		repeat (4) tick();
		check("issues while held", n_iss, n0);
		hold[h] = 1'b0;
		if (h == 4) begin
			repeat (2) tick();
			check("issues after scalar busy", n_iss, n0);
		end
		drain();
	endtask : held

	// ----------------------------------------
	// Watcher: compare each issue with its note
	// ----------------------------------------
	task automatic chk_note(input asou_note_s n);
		check("program counter", pc_o, n.pc);
		if (n.lat < 0) check("b copy", {bwe, bidx, b_o}, {1'b1, n.bx, n.av});
		if (n.lat > 1) check("reserved", ares[n.ai], 1'b1);
		fork
			begin
				int c;
				c = 0;
				while (busy === 1'b1 && c < 30) begin
					@(negedge clk);
					c++;
				end
				check("busy periods", c, n.it - 1);
			end
			begin
				repeat (n.lat - 1) @(negedge clk);
				if (n.lat > 0) check("a result", af[n.ai*24 +: 24], n.av);
			end
		join_none
	endtask : chk_note

	initial begin
		forever begin
			@(negedge clk);
			if (iss === 1'b1) begin
				n_iss++;
				chk_note(notes.pop_front());
			end
		end
	end

	// Watchdog well beyond the expected run length
	initial begin
		#2000000;
		check("watchdog", 1'b0, 1'b1);
		tally_and_finish();
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		hold = 5'h00;
		srz_d = '0;
		sj_d = '0;
		b_d = 24'h000000;
		pc_m = 24'h000000;
		lf = 16'h0043;
		err_count = 0;
		n_checks = 0;
		n_iss = 0;
		for (int n = 0; n < 8; n++) a_m[n] = 24'h000000;
		repeat (6) @(posedge clk);
		#1 rstn = 1'b1;
		check("state after reset", {pc_o, ares}, 32'h00000000);
		$display("test reset done");
		// Transmits with every buffering case
		for (int n = 0; n < 3; n++) begin
			lf = lfsr(lf);
			b_d = {lf, 8'hC3};
			sj_d = {48'hF0F0F0F0F0F0, lf};
			do_op(OP_IMM, 3'h1, lf[2:0], lf[5:3], lf, 3'(n));
			do_op(OP_IMM_INV, 3'h2, lf[8:6], lf[2:0], ~lf, 3'(n));
			do_op(OP_IMM6, 3'h3, lf[2:0], lf[5:3], 16'h0000, 3'h0);
			do_op(OP_S_TO_A, 3'h4, 3'(n), 3'h0, 16'h0000, 3'h0);
			do_op(OP_B_TO_A, 3'h5, 3'h0, 3'h0, 16'h0000, 3'h0);
			do_op(OP_A_TO_B, 3'h2, lf[2:0], lf[5:3], 16'h0000, 3'h0);
			drain();
		end
		$display("test transmits done");
		// Counts, including j zero and a negative source
		for (int n = 0; n < 6; n++) begin
			lf = lfsr(lf);
			sj_d = (n == 5) ? {1'b1, 63'h0} : {lf, ~lf, 16'h0000, lf} >> n * 9;
			do_op(OP_POP, 3'h6, 3'(n), 3'h0, 16'h0000, 3'h0);
			do_op(OP_POP, 3'h7, 3'(n), 3'h1, 16'h0000, 3'h0);
			do_op(OP_LZC, 3'h1, 3'(n), 3'h0, 16'h0000, 3'h0);
			drain();
		end
		$display("test counts done");
		// Arithmetic back to back, with dependent registers
		for (int n = 0; n < 24; n++) begin
			lf = lfsr(lf);
			do_op(n[3] ? OP_MUL : n[0] ? OP_SUB : OP_ADD, lf[2:0], n[1] ? lf[5:3] : 3'h0,
				n[2] ? lf[8:6] : 3'h0, 16'h0000, 3'h0);
		end
		drain();
		$display("test arithmetic done");
		// Every branch code against zero, positive and negative values
		for (int n = 0; n < 64; n++) begin
			lf = lfsr(lf);
			srz_d = (n % 3 == 0) ? '0 : (n % 3 == 1) ? {49'h0, lf[14:0]} : {1'b1, 47'h0, lf};
			if (n % 3 == 0) do_op(OP_S_TO_A, 3'h0, 3'h0, 3'h0, 16'h0000, 3'h0);
			else if (n % 3 == 1) do_op(OP_IMM6, 3'h0, 3'h1, lf[2:0], 16'h0000, 3'h0);
			else do_op(OP_IMM_INV, 3'h0, lf[2:0], lf[5:3], lf, 3'h0);
			do_op(7'(8 + n % 8), lf[5:3], lf[8:6], lf[11:9], lf, 3'(n / 8));
			drain();
		end
		$display("test branches done");
		// Issue holds
		held(0, OP_ADD);
		held(1, OP_IMM6);
		held(2, OP_B_TO_A);
		held(3, OP_POP);
		held(4, OP_SBR_ZERO);
		$display("test holds done");
		tally_and_finish();
	end
endmodule : address_scalar_ops_unit_bench

`default_nettype wire
